// ==== design/lfla_core.v ====
`timescale 1ns/1ps
`include "lfla_defines.vh"

// Summary of operation
// - Known unicast goes to its one port
// - Broadcast floods the broadcast flood mask except ingress
// - Unknown destination floods except ingress port
// - Seven flood masks limit flooding per type
// - 92 entries; known masks from 0-63
// - Entries 0-11 hold only own port
// - Direct-encoded entries bypass destination masks 0-63
// - Aggregation masks 64-79 pick one member
// - Source masks 80-91 remove ingress port
// - Ports accept while bit set; clearing disables
// - Table keyed by address plus VLAN
// - Hardware learning inserts unknown sources itself
// - CPU learning copies, still forwards normally
// - Secure learning redirects to CPU only
// - No learning discards learn frames only
// - Learn queue select; storm policer caps rate
// - Scan deletes aged, ages rest; hit clears
// - Automatic scans every programmed seconds period
// - CPU scan filtered by port, VLAN, both
// - Entry_remove_cmd removes the matching single entry
// - Tagged frames allowed four extra bytes
module lfla_core #(
    parameter NPORT = 12,
    parameter AW = 12,
    parameter CYC_PER_STEP = `LFLA_CYC_PER_STEP
) (
    // Clock and reset
    input wire clock,
    input wire reset,
    // Frame request from port modules
    input wire frm_valid,
    input wire [3:0] frm_port,
    input wire [47:0] frm_dmac,
    input wire [47:0] frm_smac,
    input wire [11:0] frm_vid,
    input wire [2:0] frm_class,
    input wire frm_tagged,
    input wire [13:0] frm_len,
    input wire [3:0] frm_aggr_code,
    // Forwarding decision
    output reg fwd_valid_q,
    output reg [NPORT-1:0] fwd_mask_q,
    output reg fwd_cpu_q,
    output reg [2:0] fwd_cpu_queue_q,
    output reg fwd_drop_q,
    // Per-port configuration
    input wire [NPORT-1:0] port_rx_accept,
    input wire [NPORT-1:0] learn_enable_bit,
    input wire [NPORT-1:0] learn_copy_to_cpu,
    input wire [NPORT-1:0] learn_frame_drop,
    input wire [NPORT-1:0] learn_hw_insert,
    input wire [3*NPORT-1:0] learn_extract_queue,
    input wire [NPORT-1:0] tag_length_cfg,
    input wire [14*NPORT-1:0] max_frame_len_cfg,
    // Flood masks
    input wire [NPORT-1:0] flood_mask_uc,
    input wire [NPORT-1:0] flood_mask_l2_mc,
    input wire [NPORT-1:0] flood_mask_bc,
    input wire [NPORT-1:0] flood_mask_ip4_mc_payload,
    input wire [NPORT-1:0] flood_mask_ip4_mc_control,
    input wire [NPORT-1:0] flood_mask_ip6_mc_payload,
    input wire [NPORT-1:0] flood_mask_ip6_mc_control,
    // Learn storm policer, frames per second
    input wire [15:0] storm_policer_cfg,
    // Port group table write
    input wire pgt_wr,
    input wire [6:0] pgt_addr,
    input wire [NPORT-1:0] pgt_wdata,
    // Aging
    input wire [19:0] age_period,
    input wire [1:0] age_scan_filter,
    input wire [3:0] age_filter_port,
    input wire [11:0] age_filter_vlan,
    // MAC table access
    input wire [1:0] mac_table_command,
    input wire [47:0] mac_table_access_mac,
    input wire [11:0] mac_table_access_vid,
    input wire mac_table_access_direct,
    input wire [NPORT-1:0] mac_table_access_data,
    output reg mac_table_busy_q
);

    localparam DEPTH = 1 << AW;

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    reg [NPORT-1:0] pgt_q [0:`LFLA_PGT_ENTRIES-1];
    reg [DEPTH-1:0] ent_v_q;
    reg [DEPTH-1:0] ent_age_q;
    reg [DEPTH-1:0] ent_dir_q;
    reg [47:0] ent_mac_q [0:DEPTH-1];
    reg [11:0] ent_vid_q [0:DEPTH-1];
    reg [NPORT-1:0] ent_data_q [0:DEPTH-1];

    reg st_q;
    reg [AW-1:0] scan_idx_q;
    reg [31:0] step_cnt_q;
    reg [19:0] age_sec_q;
    reg [15:0] lrn_cnt_q;
    integer i;

    function [AW-1:0] lfla_hash;
        input [47:0] mac;
        input [11:0] vid;
        integer k;
        reg [59:0] key;
        begin
            key = {vid, mac};
            lfla_hash = {AW{1'b0}};
            for (k = 0; k < 60; k = k + 1) begin
                lfla_hash[k % AW] = lfla_hash[k % AW] ^ key[k];
            end
        end
    endfunction

    // ----------------------------------------
    // Lookup and forwarding decision
    // ----------------------------------------
    wire [AW-1:0] sidx = lfla_hash(frm_smac, frm_vid);
    wire [AW-1:0] didx = lfla_hash(frm_dmac, frm_vid);
    wire [AW-1:0] cidx = lfla_hash(mac_table_access_mac, mac_table_access_vid);
    wire s_hit = ent_v_q[sidx] && ent_mac_q[sidx] == frm_smac &&
        ent_vid_q[sidx] == frm_vid;
    wire d_hit = ent_v_q[didx] && ent_mac_q[didx] == frm_dmac &&
        ent_vid_q[didx] == frm_vid;
    wire c_hit = ent_v_q[cidx] && ent_mac_q[cidx] == mac_table_access_mac &&
        ent_vid_q[cidx] == mac_table_access_vid;
    wire [13:0] max_len = max_frame_len_cfg[14*frm_port +: 14];
    wire [13:0] len_lim = max_len +
        ((frm_tagged && tag_length_cfg[frm_port]) ? `LFLA_TAG_EXTRA : 14'h0000);
    wire [NPORT-1:0] ent_d = ent_data_q[didx];
    wire [NPORT-1:0] ent_s = ent_data_q[sidx];
    wire sec_tick = step_cnt_q == CYC_PER_STEP - 1;

    reg [NPORT-1:0] flood;
    reg [NPORT-1:0] dst;
    reg accept;
    reg lrn_frame;
    reg lrn_cpu;
    reg lrn_drop;
    reg hw_ins;

    always @* begin
        case (frm_class)
            `LFLA_CLS_UC: flood = flood_mask_uc;
            `LFLA_CLS_L2MC: flood = flood_mask_l2_mc;
            `LFLA_CLS_IP4_DATA: flood = flood_mask_ip4_mc_payload;
            `LFLA_CLS_IP4_CTRL: flood = flood_mask_ip4_mc_control;
            `LFLA_CLS_IP6_DATA: flood = flood_mask_ip6_mc_payload;
            `LFLA_CLS_IP6_CTRL: flood = flood_mask_ip6_mc_control;
            default: flood = flood_mask_uc;
        endcase
        if (&frm_dmac) begin
            dst = flood_mask_bc;
        end else if (!d_hit) begin
            dst = flood;
        end else if (ent_dir_q[didx]) begin
            dst = ent_d;
        end else begin
            dst = pgt_q[ent_d[5:0]];
        end
        // Aggregation then source mask applied to every result; the source mask keeps ingress port out
        dst = dst & pgt_q[`LFLA_PGT_AGGR_BASE + frm_aggr_code];
        dst = dst & pgt_q[`LFLA_PGT_SRC_BASE + frm_port];
        accept = frm_valid && port_rx_accept[frm_port] && frm_len <= len_lim;
        lrn_frame = learn_enable_bit[frm_port] &&
            (!s_hit || ent_dir_q[sidx] || ent_s[5:0] != {2'b00, frm_port});
        hw_ins = accept && lrn_frame && learn_hw_insert[frm_port] &&
            !learn_copy_to_cpu[frm_port] && !learn_frame_drop[frm_port];
        lrn_cpu = lrn_frame && learn_copy_to_cpu[frm_port] &&
            lrn_cnt_q < storm_policer_cfg;
        lrn_drop = lrn_frame && learn_frame_drop[frm_port];
        if (lrn_drop) begin
            dst = {NPORT{1'b0}};
        end
    end

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            fwd_valid_q <= 1'b0;
            fwd_mask_q <= {NPORT{1'b0}};
            fwd_cpu_q <= 1'b0;
            fwd_cpu_queue_q <= 3'h0;
            fwd_drop_q <= 1'b0;
            lrn_cnt_q <= 16'h0000;
            step_cnt_q <= 32'h00000000;
        end else begin
            fwd_valid_q <= frm_valid;
            fwd_mask_q <= accept ? dst : {NPORT{1'b0}};
            fwd_cpu_q <= accept && lrn_cpu;
            fwd_cpu_queue_q <= learn_extract_queue[3*frm_port +: 3];
            fwd_drop_q <= !accept || (dst == {NPORT{1'b0}} && !lrn_cpu);
            step_cnt_q <= sec_tick ? 32'h00000000 : step_cnt_q + 32'h00000001;
            // Policer window is one second, counted from the shared tick
            if (sec_tick) begin
                lrn_cnt_q <= 16'h0000;
            end else if (accept && lrn_cpu) begin
                lrn_cnt_q <= lrn_cnt_q + 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // Port group table
    // ----------------------------------------
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            for (i = 0; i < `LFLA_PGT_ENTRIES; i = i + 1) begin
                if (i <= `LFLA_PGT_UC_LAST) begin
                    pgt_q[i] <= {{(NPORT-1){1'b0}}, 1'b1} << i;
                end else if (i <= `LFLA_PGT_DST_LAST) begin
                    pgt_q[i] <= `LFLA_PGT_MC_RESET;
                end else if (i < `LFLA_PGT_SRC_BASE) begin
                    pgt_q[i] <= `LFLA_PGT_AGGR_RESET;
                end else begin
                    pgt_q[i] <= ~({{(NPORT-1){1'b0}}, 1'b1} << (i - `LFLA_PGT_SRC_BASE));
                end
            end
        end else if (pgt_wr && pgt_addr > `LFLA_PGT_UC_LAST &&
                pgt_addr < `LFLA_PGT_ENTRIES) begin
            pgt_q[pgt_addr] <= pgt_wdata;
        end
    end

    // ----------------------------------------
    // Commands, aging and learning
    // ----------------------------------------
    wire scan_match = (!age_scan_filter[0] || (!ent_dir_q[scan_idx_q] &&
        ent_data_q[scan_idx_q][5:0] == {2'b00, age_filter_port})) &&
        (!age_scan_filter[1] || ent_vid_q[scan_idx_q] == age_filter_vlan);
    wire auto_due = age_period != 20'h00000 && age_sec_q >= age_period;
    wire cmd_take = st_q == `LFLA_ST_IDLE && !mac_table_busy_q &&
        mac_table_command != `LFLA_CMD_IDLE;

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            st_q <= `LFLA_ST_IDLE;
            scan_idx_q <= {AW{1'b0}};
            age_sec_q <= 20'h00000;
            mac_table_busy_q <= 1'b0;
            ent_v_q <= {DEPTH{1'b0}};
            ent_age_q <= {DEPTH{1'b0}};
            ent_dir_q <= {DEPTH{1'b0}};
        end else begin
            if (sec_tick) begin
                age_sec_q <= age_sec_q + 20'h00001;
            end
            // Frame side updates lose to command or scan writes in the same cycle
            if (hw_ins) begin
                ent_v_q[sidx] <= 1'b1;
                ent_age_q[sidx] <= 1'b0;
                ent_dir_q[sidx] <= 1'b0;
                ent_mac_q[sidx] <= frm_smac;
                ent_vid_q[sidx] <= frm_vid;
                ent_data_q[sidx] <= {{(NPORT-4){1'b0}}, frm_port};
            end else if (frm_valid && s_hit) begin
                ent_age_q[sidx] <= 1'b0;
            end
            case (st_q)
                `LFLA_ST_IDLE: begin
                    mac_table_busy_q <= 1'b0;
                    if (cmd_take && mac_table_command == `LFLA_CMD_LEARN) begin
                        mac_table_busy_q <= 1'b1;
                        ent_v_q[cidx] <= 1'b1;
                        ent_age_q[cidx] <= 1'b0;
                        ent_dir_q[cidx] <= mac_table_access_direct;
                        ent_mac_q[cidx] <= mac_table_access_mac;
                        ent_vid_q[cidx] <= mac_table_access_vid;
                        ent_data_q[cidx] <= mac_table_access_data;
                    end else if (cmd_take && mac_table_command == `LFLA_CMD_ENTRY_REMOVE_CMD) begin
                        mac_table_busy_q <= 1'b1;
                        if (c_hit) begin
                            ent_v_q[cidx] <= 1'b0;
                        end
                    end else if ((cmd_take && mac_table_command == `LFLA_CMD_AGE) ||
                            auto_due) begin
                        mac_table_busy_q <= 1'b1;
                        st_q <= `LFLA_ST_SCAN;
                        scan_idx_q <= {AW{1'b0}};
                        if (auto_due) begin
                            age_sec_q <= 20'h00000;
                        end
                    end
                end
                `LFLA_ST_SCAN: begin
                    if (ent_v_q[scan_idx_q] && scan_match) begin
                        if (ent_age_q[scan_idx_q]) begin
                            ent_v_q[scan_idx_q] <= 1'b0;
                        end else begin
                            ent_age_q[scan_idx_q] <= 1'b1;
                        end
                    end
                    scan_idx_q <= scan_idx_q + {{(AW-1){1'b0}}, 1'b1};
                    if (&scan_idx_q) begin
                        st_q <= `LFLA_ST_IDLE;
                        mac_table_busy_q <= 1'b0;
                    end
                end
                default: st_q <= `LFLA_ST_IDLE;
            endcase
        end
    end

endmodule

// ==== design/lfla_defines.vh ====
`ifndef LFLA_DEFINES_VH
`define LFLA_DEFINES_VH

// ----------------------------------------
// Port group table layout
// ----------------------------------------
`define LFLA_PGT_ENTRIES 92
`define LFLA_PGT_UC_LAST 11
`define LFLA_PGT_DST_LAST 63
`define LFLA_PGT_AGGR_BASE 64
`define LFLA_PGT_SRC_BASE 80
`define LFLA_PGT_MC_RESET 12'h000
`define LFLA_PGT_AGGR_RESET 12'hfff

// ----------------------------------------
// Timing
// ----------------------------------------
`define LFLA_CLK_HZ 200000000
`define LFLA_AGE_STEP_S 1
`define LFLA_CYC_PER_STEP (`LFLA_CLK_HZ * `LFLA_AGE_STEP_S)
`define LFLA_AGE_MAX_S 1036800

// ----------------------------------------
// Frame length
// ----------------------------------------
`define LFLA_TAG_EXTRA 14'h0004

// ----------------------------------------
// MAC table commands
// ----------------------------------------
`define LFLA_CMD_IDLE 2'h0
`define LFLA_CMD_LEARN 2'h1
`define LFLA_CMD_ENTRY_REMOVE_CMD 2'h2
`define LFLA_CMD_AGE 2'h3

// ----------------------------------------
// Frame classes for flood mask selection
// ----------------------------------------
`define LFLA_CLS_UC 3'h0
`define LFLA_CLS_L2MC 3'h1
`define LFLA_CLS_IP4_DATA 3'h2
`define LFLA_CLS_IP4_CTRL 3'h3
`define LFLA_CLS_IP6_DATA 3'h4
`define LFLA_CLS_IP6_CTRL 3'h5

// ----------------------------------------
// Command state machine
// ----------------------------------------
`define LFLA_ST_IDLE 1'b0
`define LFLA_ST_SCAN 1'b1

`endif

// ==== dv/lfla_core_asserts.sv ====
`timescale 1ns/1ps
`include "lfla_defines.vh"
module lfla_core_asserts #(
    parameter AW = 12
) (
    // Clock and reset
    input wire clock,
    input wire reset,
    // Frame path
    input wire frm_valid,
    input wire [3:0] frm_port,
    input wire [11:0] port_rx_accept,
    input wire fwd_valid_q,
    input wire [11:0] fwd_mask_q,
    input wire fwd_cpu_q,
    input wire fwd_drop_q,
    // Command path
    input wire [1:0] mac_table_command,
    input wire mac_table_busy_q
);
    localparam [13:0] SCAN_LEN = 14'h0001 << AW;
    reg [13:0] busy_cnt_q;
    reg busy_prev_q;
    // The core can take a command in the first low busy cycle; cmd_go also waits for busy_prev_q low
    wire cmd_go = !mac_table_busy_q && !busy_prev_q && (mac_table_command != `LFLA_CMD_IDLE);
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            busy_cnt_q <= 14'h0000;
            busy_prev_q <= 1'b0;
        end else begin
            busy_cnt_q <= mac_table_busy_q ? busy_cnt_q + 14'h0001 : 14'h0000;
            busy_prev_q <= mac_table_busy_q;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    property p_fwd_answer; frm_valid |=> fwd_valid_q; endproperty
    a_fwd_answer: assert property (p_fwd_answer) else $error("frame got no decision");
    property p_fwd_quiet; !frm_valid |=> !fwd_valid_q; endproperty
    a_fwd_quiet: assert property (p_fwd_quiet) else $error("decision without frame");
    property p_rx_refuse;
        frm_valid && !port_rx_accept[frm_port] |=> fwd_drop_q && fwd_mask_q == 12'h000 && !fwd_cpu_q;
    endproperty
    a_rx_refuse: assert property (p_rx_refuse) else $error("disabled port frame passed");
    property p_no_echo; frm_valid |=> !fwd_mask_q[$past(frm_port)]; endproperty
    a_no_echo: assert property (p_no_echo) else $error("frame sent back to ingress");
    property p_drop_empty; fwd_valid_q && fwd_drop_q |-> fwd_mask_q == 12'h000 && !fwd_cpu_q; endproperty
    a_drop_empty: assert property (p_drop_empty) else $error("dropped frame has targets");
    property p_short_cmd;
        cmd_go && mac_table_command != `LFLA_CMD_AGE |=> mac_table_busy_q ##1 !mac_table_busy_q;
    endproperty
    a_short_cmd: assert property (p_short_cmd) else $error("learn or entry_remove_cmd busy wrong");
    property p_scan_busy; cmd_go && mac_table_command == `LFLA_CMD_AGE |=> mac_table_busy_q [*8]; endproperty
    a_scan_busy: assert property (p_scan_busy) else $error("age scan not busy");
    property p_busy_len;
        $fell(mac_table_busy_q) |-> busy_cnt_q == 14'h0001 || busy_cnt_q == SCAN_LEN;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    c_drop: cover property (fwd_valid_q && fwd_drop_q);
    c_cpu: cover property (fwd_valid_q && fwd_cpu_q);
    c_scan: cover property (cmd_go && mac_table_command == `LFLA_CMD_AGE);
endmodule
bind lfla_core lfla_core_asserts #(.AW(AW)) i_chk (.clock, .reset, .frm_valid, .frm_port,
    .port_rx_accept, .fwd_valid_q, .fwd_mask_q, .fwd_cpu_q, .fwd_drop_q, .mac_table_command,
    .mac_table_busy_q);

// ==== dv/lfla_port_model.sv ====
`timescale 1ns/1ps
module lfla_port_model (
    // Clock
    input wire clock,
    // Frame request
    output reg frm_valid,
    output reg [3:0] frm_port,
    output reg [47:0] frm_dmac,
    output reg [47:0] frm_smac,
    output reg [11:0] frm_vid,
    output reg [2:0] frm_class,
    output reg frm_tagged,
    output reg [13:0] frm_len,
    output reg [3:0] frm_aggr_code
);
    initial begin
        {frm_valid, frm_port, frm_dmac, frm_smac, frm_vid} = 113'h0;
        {frm_class, frm_tagged, frm_len, frm_aggr_code} = 22'h0;
    end
    // Addresses, VLAN and length are inverted once the pulse ends so stale keys are never trusted
    task send(input [3:0] p, input [47:0] d, input [47:0] s, input [11:0] v, input [2:0] c,
        input t, input [13:0] l);
        begin
            frm_valid <= 1'b1;
            {frm_port, frm_dmac, frm_smac, frm_vid} <= {p, d, s, v};
            {frm_class, frm_tagged, frm_len} <= {c, t, l};
            @(posedge clock);
            frm_valid <= 1'b0;
            {frm_dmac, frm_smac, frm_vid, frm_len} <= ~{d, s, v, l};
        end
    endtask
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`include "lfla_defines.vh"
module tb_top;
    reg clock = 1'b0;
    reg reset = 1'b1;
    wire frm_valid, frm_tagged, fwd_valid_q, fwd_cpu_q, fwd_drop_q, mac_table_busy_q;
    wire [3:0] frm_port, frm_aggr_code;
    wire [47:0] frm_dmac, frm_smac;
    wire [11:0] frm_vid, fwd_mask_q;
    wire [2:0] frm_class, fwd_cpu_queue_q;
    wire [13:0] frm_len;
    reg [11:0] port_rx_accept, learn_enable_bit, learn_copy_to_cpu, learn_frame_drop;
    reg [11:0] learn_hw_insert, tag_length_cfg, flood_mask_uc, flood_mask_l2_mc, flood_mask_bc;
    reg [11:0] flood_mask_ip4_mc_payload, flood_mask_ip4_mc_control;
    reg [11:0] flood_mask_ip6_mc_payload, flood_mask_ip6_mc_control;
    reg [11:0] pgt_wdata, age_filter_vlan, mac_table_access_vid, mac_table_access_data, f_vid;
    reg [35:0] learn_extract_queue;
    reg [167:0] max_frame_len_cfg;
    reg [15:0] storm_policer_cfg;
    reg [6:0] pgt_addr;
    reg [19:0] age_period;
    reg [1:0] age_scan_filter, mac_table_command;
    reg [3:0] age_filter_port;
    reg [47:0] mac_table_access_mac;
    reg [13:0] f_len;
    reg [2:0] f_cls;
    reg pgt_wr, mac_table_access_direct, f_tag;
    integer n_fail = 0, samples_checked = 0, cycles = 0, i;
    // Short second so aging runs in a few thousand cycles
    lfla_core #(.CYC_PER_STEP(20)) i_dut (.*);
    lfla_port_model i_port (.*);
    always #2.5 clock = ~clock;
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles > 60000) begin
            n_fail = n_fail + 1;
            wrap_up;
        end
    end
    // ----------
    // Helpers
    // ----------
    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", samples_checked, n_fail);
            if (n_fail == 0 && samples_checked > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    task chk(input [15:0] got, input [15:0] exp, input string what);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("MISMATCH %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task frm(input [3:0] p, input [47:0] d, input [47:0] s, input [11:0] m, input [1:0] cd);
        begin
            @(posedge clock);
            i_port.send(p, d, s, f_vid, f_cls, f_tag, f_len);
            #1;
            chk({4'h0, fwd_mask_q}, {4'h0, m}, "mask");
            chk({13'h0, fwd_valid_q, fwd_cpu_q, fwd_drop_q}, {13'h0, 1'b1, cd}, "valid_cpu_drop");
        end
    endtask
    task cmd(input [1:0] c, input [47:0] a, input dir, input [11:0] dat);
        begin
            @(posedge clock);
            mac_table_command <= c;
            {mac_table_access_mac, mac_table_access_vid} <= {a, 12'h001};
            {mac_table_access_direct, mac_table_access_data} <= {dir, dat};
            @(posedge clock);
            mac_table_command <= `LFLA_CMD_IDLE;
            #1;
            chk({15'h0, mac_table_busy_q}, 16'h0001, "busy");
            while (mac_table_busy_q) begin
                @(posedge clock);
                #1;
            end
            @(posedge clock);
        end
    endtask
    task pgt(input [6:0] a, input [11:0] w);
        begin
            @(posedge clock);
            {pgt_wr, pgt_addr, pgt_wdata} <= {1'b1, a, w};
            @(posedge clock);
            pgt_wr <= 1'b0;
        end
    endtask
    // ----------
    // Scenarios
    // ----------
    task t_flood;
        begin
            frm(4'h2, {48{1'b1}}, 48'h11, 12'hffb, 2'h0);
            @(posedge clock);
            {flood_mask_uc, flood_mask_l2_mc, flood_mask_ip4_mc_payload} <= 36'h01f02f04f;
            {flood_mask_ip4_mc_control, flood_mask_ip6_mc_payload} <= 24'h08f10f;
            {flood_mask_ip6_mc_control, flood_mask_bc} <= 24'h20f40f;
            for (i = 0; i < 6; i = i + 1) begin
                f_cls = i[2:0];
                frm(4'h2, 48'ha0 + i, 48'h12 + i, ((12'h010 << i) | 12'h00f) & 12'hffb, 2'h0);
            end
            f_cls = 3'h0;
            frm(4'h2, {48{1'b1}}, 48'h20, 12'h40b, 2'h0);
        end
    endtask
    task t_learn;
        begin
            frm(4'h5, 48'ha7, 48'ha1, 12'h01f, 2'h0);
            pgt(7'd5, 12'hfff);
            frm(4'h3, 48'ha1, 48'hb3, 12'h020, 2'h0);
            f_vid = 12'h002;
            frm(4'h3, 48'ha1, 48'hb3, 12'h017, 2'h0);
            f_vid = 12'h001;
        end
    endtask
    task t_modes;
        begin
            for (i = 0; i < 3; i = i + 1) begin
                @(posedge clock);
                learn_copy_to_cpu[7] <= (i != 2);
                learn_frame_drop[7] <= (i != 0);
                frm(4'h7, 48'ha9, 48'hc0 + i, (i == 0) ? 12'h01f : 12'h000, {i != 2, i == 2});
                if (i != 2)
                    chk({13'h0, fwd_cpu_queue_q}, 16'h0005, "queue");
            end
            // A zero limit must stop every CPU copy while forwarding goes on
            @(posedge clock);
            {learn_copy_to_cpu[7], learn_frame_drop[7], storm_policer_cfg} <= 18'h20000;
            frm(4'h7, 48'ha9, 48'hc4, 12'h01f, 2'h0);
            @(posedge clock);
            {learn_copy_to_cpu[7], learn_frame_drop[7], storm_policer_cfg} <= 18'h1ffff;
            cmd(`LFLA_CMD_LEARN, 48'hd0, 1'b0, 12'h007);
            frm(4'h7, 48'ha9, 48'hd0, 12'h01f, 2'h0);
        end
    endtask
    task t_mc;
        begin
            pgt(7'd20, 12'h0c3);
            cmd(`LFLA_CMD_LEARN, 48'h01005e000001, 1'b0, 12'd20);
            frm(4'h0, 48'h01005e000001, 48'he0, 12'h0c2, 2'h0);
            pgt(7'd64, 12'hf7f);
            frm(4'h0, 48'h01005e000001, 48'he0, 12'h042, 2'h0);
            pgt(7'd64, 12'hfff);
            cmd(`LFLA_CMD_LEARN, 48'h333300000001, 1'b1, 12'h30c);
            frm(4'h2, 48'h333300000001, 48'he1, 12'h308, 2'h0);
        end
    endtask
    task t_age;
        begin
            cmd(`LFLA_CMD_ENTRY_REMOVE_CMD, 48'ha1, 1'b0, 12'h000);
            frm(4'h3, 48'ha1, 48'hb3, 12'h017, 2'h0);
            @(posedge clock);
            {age_scan_filter, age_filter_port} <= 6'h13;
            cmd(`LFLA_CMD_AGE, 48'h0, 1'b0, 12'h000);
            cmd(`LFLA_CMD_AGE, 48'h0, 1'b0, 12'h000);
            frm(4'h5, 48'hb3, 48'ha1, 12'h01f, 2'h0);
            frm(4'h5, 48'he0, 48'ha1, 12'h001, 2'h0);
            // VLAN-only scans must drop the VLAN 2 copy and spare VLAN 1
            f_vid = 12'h002;
            frm(4'h5, 48'hb3, 48'ha1, 12'h01f, 2'h0);
            @(posedge clock);
            {age_scan_filter, age_filter_vlan} <= 14'h2002;
            cmd(`LFLA_CMD_AGE, 48'h0, 1'b0, 12'h000);
            cmd(`LFLA_CMD_AGE, 48'h0, 1'b0, 12'h000);
            frm(4'h3, 48'ha1, 48'hb3, 12'h017, 2'h0);
            f_vid = 12'h001;
            frm(4'h3, 48'ha1, 48'hb3, 12'h020, 2'h0);
            @(posedge clock);
            age_scan_filter <= 2'h0;
            cmd(`LFLA_CMD_AGE, 48'h0, 1'b0, 12'h000);
            frm(4'h0, 48'ha1, 48'he0, 12'h020, 2'h0);
            cmd(`LFLA_CMD_AGE, 48'h0, 1'b0, 12'h000);
            frm(4'h5, 48'he0, 48'ha1, 12'h001, 2'h0);
            cmd(`LFLA_CMD_AGE, 48'h0, 1'b0, 12'h000);
            cmd(`LFLA_CMD_AGE, 48'h0, 1'b0, 12'h000);
            frm(4'h5, 48'he0, 48'ha1, 12'h01f, 2'h0);
        end
    endtask
    task t_rx;
        begin
            @(posedge clock);
            port_rx_accept[4] <= 1'b0;
            frm(4'h4, 48'ha1, 48'hf1, 12'h000, 2'h1);
            {f_tag, f_len} = 15'h45f2;
            frm(4'h2, 48'ha1, 48'hf2, 12'h020, 2'h0);
            f_len = 14'h05f3;
            frm(4'h2, 48'ha1, 48'hf3, 12'h000, 2'h1);
            {f_tag, f_len} = 15'h05ef;
            frm(4'h2, 48'ha1, 48'hf4, 12'h000, 2'h1);
            f_len = 14'h0040;
        end
    endtask
    task t_auto;
        begin
            frm(4'h6, 48'ha1, 48'hf0, 12'h020, 2'h0);
            @(posedge clock);
            age_period <= 20'h00001;
            repeat (8400) @(posedge clock);
            age_period <= 20'h00000;
            #1;
            while (mac_table_busy_q) begin
                @(posedge clock);
                #1;
            end
            frm(4'h5, 48'hf0, 48'ha1, 12'h01f, 2'h0);
        end
    endtask
    initial begin
        {port_rx_accept, learn_enable_bit, learn_copy_to_cpu, learn_frame_drop} = 48'hfff_fff_000_000;
        {learn_hw_insert, tag_length_cfg, learn_extract_queue} = 60'hf7f_fff_000a00000;
        max_frame_len_cfg = {12{14'h05ee}};
        {flood_mask_uc, flood_mask_l2_mc, flood_mask_bc, flood_mask_ip4_mc_payload} = {48{1'b1}};
        {flood_mask_ip4_mc_control, flood_mask_ip6_mc_payload, flood_mask_ip6_mc_control} = {36{1'b1}};
        {storm_policer_cfg, pgt_wr, pgt_addr, pgt_wdata, age_period} = 56'hffff_0000000000;
        {age_scan_filter, age_filter_port, age_filter_vlan, mac_table_command} = 20'h00000;
        {mac_table_access_mac, mac_table_access_vid, mac_table_access_direct} = 61'h0;
        mac_table_access_data = 12'h000;
        {f_vid, f_len, f_cls, f_tag} = 30'h0040400;
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        t_flood;
        t_learn;
        t_modes;
        t_mc;
        t_age;
        t_rx;
        t_auto;
        wrap_up;
    end
endmodule
